// ---- color_proximity_sensing_map.svh ----
// Register map, field positions, reset values and timing for the sensor control block
// Behaviour
// - Ambient mode picks clear, clear+IR, or all channels
// - Enabled ambient channels latch together in parallel
// - Ambient interrupt from window thresholds and persistence
// - Interrupt latched until status register is read or its bit is written with one
// - LED current set in 10 mA steps, 0-110 mA
// - IR path switches between DC ambient and AC proximity
// - Ambient rejection sampling tracks the LED pulse
// - Exactly one LED pulse per proximity measurement
// - Every result lands in a readable output register
`ifndef COLOR_PROXIMITY_SENSING_MAP_SVH
`define COLOR_PROXIMITY_SENSING_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_STATUS 5'h00
`define IDX_MAIN_CFG 5'h01
`define IDX_AMB_CFG 5'h02
`define IDX_PROXIMITY_SENSING_CFG 5'h03
`define IDX_CLEAR_HI 5'h04
`define IDX_IRCOMP_HI 5'h0e
`define IDX_IRCOMP_LO 5'h0f
`define IDX_PROXIMITY_SENSING_HI 5'h10
`define IDX_PROXIMITY_SENSING_LO 5'h11
`define IDX_TEMP_HI 5'h12
`define IDX_TEMP_LO 5'h13
`define IDX_UPTH_HI 5'h14
`define IDX_UPTH_LO 5'h15
`define IDX_LOTH_HI 5'h16
`define IDX_LOTH_LO 5'h17
`define IDX_PERSIST 5'h18
`define IDX_IRQ_MASK 5'h19
`define IDX_PROXIMITY_SENSING_TH 5'h1a

// Reset values
`define RST_STATUS 8'h04
`define RST_MAIN_CFG 8'h00
`define RST_AMB_CFG 8'h20
`define RST_PROXIMITY_SENSING_CFG 8'h02
`define RST_MASK 8'h00

// Field positions
`define BIT_AMB_INT 0
`define BIT_PROXIMITY_SENSING_INT 1
`define BIT_PWRON 2
`define MODE_LSB 2
`define TEMPEN_BIT 5
`define DRIVE_LSB 4
`define DRIVE_MAX 4'hb

// Timing
`define CLK_PERIOD_NS 5
`define LED_PULSE_NS 1000
`define REPEAT_NS 100000

`endif

// ---- color_proximity_sensing_pkg.sv ----
// Types shared by the sensor control block
package color_proximity_sensing_pkg;

  // Measurement sequencer, Gray coded from SEQ_IDLE through SEQ_AMB, SEQ_LED and SEQ_PROXIMITY_SENSING to SEQ_WAIT
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_AMB = 3'b001,
    SEQ_LED = 3'b011,
    SEQ_PROXIMITY_SENSING = 3'b010,
    SEQ_WAIT = 3'b110
  } seq_e;

  typedef struct packed {
    seq_e seq;
    logic [15:0] cnt;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] main_cfg;
    logic [7:0] amb_cfg;
    logic [7:0] proximity_sensing_cfg;
    logic [7:0] persist;
    logic [13:0] up_th;
    logic [13:0] lo_th;
    logic [7:0] proximity_sensing_th;
    logic [5:0][13:0] res;
    logic [9:0] proximity_sensing;
    logic [3:0] pers_cnt;
    logic [4:0] ch_en;
    logic amb_start;
    logic proximity_sensing_start;
    logic led_on;
    logic rej_sample;
    logic ir_ac;
    logic [3:0] led_code;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic int_oe;
  } state_s;

endpackage

// ---- color_proximity_sensing_sensor_control.sv ----
// Sensor control: APB registers, measurement sequencer, LED pulse, interrupt
`timescale 1ns/1ps
`include "color_proximity_sensing_map.svh"

module color_proximity_sensing_sensor_control #(
  parameter int REPEAT_CYCLES = `REPEAT_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Ambient converters: clear, red, green, blue, ir, temperature
  output logic [4:0] amb_ch_en,
  output logic amb_start,
  input wire logic amb_done,
  input wire logic [13:0] adc_clear,
  input wire logic [13:0] adc_red,
  input wire logic [13:0] adc_green,
  input wire logic [13:0] adc_blue,
  input wire logic [13:0] adc_ir,
  input wire logic [13:0] adc_temp,
  // Proximity path
  output logic ir_path_ac,
  output logic rej_sample,
  output logic proximity_sensing_start,
  input wire logic proximity_sensing_done,
  input wire logic [9:0] adc_proximity_sensing,
  // LED driver
  output logic led_pulse,
  output logic [3:0] led_current_drive,
  // Interrupt
  output logic irq,
  output logic int_pin_oe
);
  import color_proximity_sensing_pkg::*;

  localparam int LED_RAW = (`LED_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int LED_CYC = (LED_RAW < 1) ? 1 : LED_RAW;
  localparam logic [15:0] LED_LAST = 16'(LED_CYC - 1);
  localparam logic [15:0] REPEAT_LAST = 16'(REPEAT_CYCLES - 1);

  state_s s;
  state_s n;

  // Channel enables per mode: {ir, blue, green, red, clear}
  function automatic logic [4:0] amb_channels(input logic [2:0] mode);
    case (mode)
      3'h0: amb_channels = 5'h01;
      3'h1: amb_channels = 5'h11;
      3'h2: amb_channels = 5'h1f;
      3'h4: amb_channels = 5'h01;
      3'h5: amb_channels = 5'h1f;
      default: amb_channels = 5'h00;
    endcase
  endfunction

  // Modes that add a proximity measurement to each round
  function automatic logic proximity_sensing_wanted(input logic [2:0] mode);
    proximity_sensing_wanted = (mode == 3'h3) || (mode == 3'h4) || (mode == 3'h5);
  endfunction

  // Read mux over the byte registers; hi/lo split of 14-bit results
  function automatic logic [7:0] hi14(input logic [13:0] v);
    hi14 = {2'b00, v[13:8]};
  endfunction

  function automatic logic [7:0] read_reg(input state_s st, input logic [4:0] idx);
    read_reg = 8'h00;
    case (idx)
      `IDX_STATUS: read_reg = st.status;
      `IDX_MAIN_CFG: read_reg = st.main_cfg;
      `IDX_AMB_CFG: read_reg = st.amb_cfg;
      `IDX_PROXIMITY_SENSING_CFG: read_reg = st.proximity_sensing_cfg;
      5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c: read_reg = hi14(st.res[(idx - 5'h04) >> 1]);
      5'h05, 5'h07, 5'h09, 5'h0b, 5'h0d: read_reg = st.res[(idx - 5'h05) >> 1][7:0];
      `IDX_PROXIMITY_SENSING_HI: read_reg = {6'h00, st.proximity_sensing[9:8]};
      `IDX_PROXIMITY_SENSING_LO: read_reg = st.proximity_sensing[7:0];
      `IDX_TEMP_HI: read_reg = hi14(st.res[5]);
      `IDX_TEMP_LO: read_reg = st.res[5][7:0];
      `IDX_UPTH_HI: read_reg = hi14(st.up_th);
      `IDX_UPTH_LO: read_reg = st.up_th[7:0];
      `IDX_LOTH_HI: read_reg = hi14(st.lo_th);
      `IDX_LOTH_LO: read_reg = st.lo_th[7:0];
      `IDX_PERSIST: read_reg = st.persist;
      `IDX_IRQ_MASK: read_reg = st.mask;
      `IDX_PROXIMITY_SENSING_TH: read_reg = st.proximity_sensing_th;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic [4:0] idx;
    logic mapped;
    logic acc;
    logic wr;
    logic [7:0] wb;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic [2:0] mode;
    logic outside;
    logic [3:0] need;
    idx = paddr[6:2];
    mapped = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00) && (idx <= `IDX_PROXIMITY_SENSING_TH);
    acc = psel && penable && s.pready;
    wr = acc && pwrite && mapped && pstrb[0];
    wb = pwdata[7:0];
    set_bits = 8'h00;
    clr_bits = 8'h00;
    mode = s.main_cfg[`MODE_LSB +: 3];
    outside = 1'b0;
    need = 4'h1 << s.persist[1:0];
    n = s;
    n.amb_start = 1'b0;
    n.proximity_sensing_start = 1'b0;

    // Bus slave: data latched in setup, answer one cycle later
    n.pready = psel && !penable && !s.pready;
    // Error flag stands only with pready; unmapped places answer zero
    n.pslverr = n.pready && !mapped;
    if (psel && !penable) begin
      n.prdata = mapped ? {24'h000000, read_reg(s, idx)} : 32'h00000000;
    end

    // Configuration writes; result registers ignore writes
    if (wr) begin
      case (idx)
        `IDX_MAIN_CFG: n.main_cfg = wb;
        `IDX_AMB_CFG: n.amb_cfg = wb;
        `IDX_PROXIMITY_SENSING_CFG: n.proximity_sensing_cfg = wb;
        `IDX_UPTH_HI: n.up_th[13:8] = wb[5:0];
        `IDX_UPTH_LO: n.up_th[7:0] = wb;
        `IDX_LOTH_HI: n.lo_th[13:8] = wb[5:0];
        `IDX_LOTH_LO: n.lo_th[7:0] = wb;
        `IDX_PERSIST: n.persist = {6'h00, wb[1:0]};
        `IDX_IRQ_MASK: n.mask = {5'h00, wb[2:0]};
        `IDX_PROXIMITY_SENSING_TH: n.proximity_sensing_th = wb;
        default: n.mask = n.mask;
      endcase
    end

    // Status clears: a read clears all, a write clears the ones written
    if (acc && mapped && idx == `IDX_STATUS) begin
      clr_bits = pwrite ? (pstrb[0] ? wb : 8'h00) : 8'hff;
    end

    // Measurement sequencer
    case (s.seq)
      SEQ_IDLE: begin
        n.cnt = 16'h0000;
        n.ch_en = amb_channels(mode);
        if (amb_channels(mode) != 5'h00) begin
          n.amb_start = 1'b1;
          n.seq = SEQ_AMB;
        end else if (proximity_sensing_wanted(mode)) begin
          n.ir_ac = 1'b1;
          n.led_on = 1'b1;
          n.rej_sample = 1'b1;
          n.seq = SEQ_LED;
        end
      end
      SEQ_AMB: begin
        if (amb_done) begin
          // All enabled channels captured on the same edge
          for (int i = 0; i < 5; i++) begin
            if (s.ch_en[i]) begin
              n.res[i] = (i == 0) ? adc_clear : (i == 1) ? adc_red :
                (i == 2) ? adc_green : (i == 3) ? adc_blue : adc_ir;
            end
          end
          if (s.amb_cfg[`TEMPEN_BIT]) begin
            n.res[5] = adc_temp;
          end
          // Window check with persistence on the clear channel
          outside = (adc_clear > s.up_th) || (adc_clear < s.lo_th);
          if (!outside) begin
            n.pers_cnt = 4'h0;
          end else if (s.pers_cnt + 4'h1 >= need) begin
            set_bits[`BIT_AMB_INT] = 1'b1;
            n.pers_cnt = need;
          end else begin
            n.pers_cnt = s.pers_cnt + 4'h1;
          end
          if (proximity_sensing_wanted(mode)) begin
            n.ir_ac = 1'b1;
            n.led_on = 1'b1;
            n.rej_sample = 1'b1;
            n.seq = SEQ_LED;
          end else begin
            n.seq = SEQ_WAIT;
          end
        end
      end
      SEQ_LED: begin
        // One pulse only; rejection sampling follows it exactly
        if (s.cnt >= LED_LAST) begin
          n.cnt = 16'h0000;
          n.led_on = 1'b0;
          n.rej_sample = 1'b0;
          n.proximity_sensing_start = 1'b1;
          n.seq = SEQ_PROXIMITY_SENSING;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
      SEQ_PROXIMITY_SENSING: begin
        if (proximity_sensing_done) begin
          n.proximity_sensing = adc_proximity_sensing;
          n.ir_ac = 1'b0;
          if (adc_proximity_sensing[9:2] > s.proximity_sensing_th) begin
            set_bits[`BIT_PROXIMITY_SENSING_INT] = 1'b1;
          end
          n.seq = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (s.cnt >= REPEAT_LAST) begin
          n.cnt = 16'h0000;
          n.seq = SEQ_IDLE;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
      default: begin
        n.seq = SEQ_IDLE;
      end
    endcase

    // LED current code, clamped to the top step of 110 mA
    if (n.led_on) begin
      n.led_code = (s.proximity_sensing_cfg[`DRIVE_LSB +: 4] > `DRIVE_MAX) ? `DRIVE_MAX :
        s.proximity_sensing_cfg[`DRIVE_LSB +: 4];
    end else begin
      n.led_code = 4'h0;
    end

    // Sticky status: a new event beats a clear in the same cycle
    n.status = (s.status & ~clr_bits) | set_bits;
    n.irq = |(n.status & n.mask);
    n.int_oe = n.irq;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
      s.seq <= SEQ_IDLE;
      s.status <= `RST_STATUS;
      s.main_cfg <= `RST_MAIN_CFG;
      s.amb_cfg <= `RST_AMB_CFG;
      s.proximity_sensing_cfg <= `RST_PROXIMITY_SENSING_CFG;
      s.mask <= `RST_MASK;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign amb_ch_en = s.ch_en;
  assign amb_start = s.amb_start;
  assign ir_path_ac = s.ir_ac;
  assign rej_sample = s.rej_sample;
  assign proximity_sensing_start = s.proximity_sensing_start;
  assign led_pulse = s.led_on;
  assign led_current_drive = s.led_code;
  assign irq = s.irq;
  assign int_pin_oe = s.int_oe;

endmodule

// ---- color_proximity_sensing_chk.sv ----
// Port assertions for the sensor control block
`timescale 1ns/1ps
module color_proximity_sensing_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sequencer and LED
  input wire logic amb_start,
  input wire logic ir_path_ac,
  input wire logic rej_sample,
  input wire logic proximity_sensing_start,
  input wire logic led_pulse,
  input wire logic [3:0] led_current_drive,
  // Interrupt
  input wire logic irq,
  input wire logic int_pin_oe
);
  logic [7:0] hi_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Length of the current LED pulse so far
  always_ff @(posedge clk_sys) begin
    if (reset || !led_pulse) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end
  a_pready_next: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  a_rej_sync: assert property (rej_sample == led_pulse)
    else $error("rejection sampling off the LED pulse");
  a_drive_gate: assert property (!led_pulse |-> led_current_drive == 4'h0)
    else $error("drive current outside pulse");
  a_drive_max: assert property (led_current_drive <= 4'hb)
    else $error("drive code above 110 mA");
  a_pulse_len: assert property ($fell(led_pulse) |-> hi_cnt == 8'd200)
    else $error("LED pulse width wrong");
  a_proximity_sensing_after: assert property ($fell(led_pulse) |-> proximity_sensing_start)
    else $error("no proximity start after pulse");
  a_led_ac: assert property (led_pulse |-> ir_path_ac)
    else $error("IR path not in AC use during pulse");
  a_irq_pin: assert property (int_pin_oe == irq)
    else $error("pin enable differs from irq");
  a_start_one: assert property (amb_start |=> !amb_start)
    else $error("ambient start longer than one cycle");
endmodule

bind color_proximity_sensing_sensor_control color_proximity_sensing_chk i_chk (.*);

// ---- color_proximity_sensing_conv_model.sv ----
// Converter model: answers start pulses after a set delay
`timescale 1ns/1ps
module color_proximity_sensing_conv_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Requests and bench settings
  input wire logic amb_start,
  input wire logic proximity_sensing_start,
  input wire logic [13:0] amb_val,
  input wire logic [9:0] proximity_sensing_val,
  input wire logic [7:0] dly,
  // Results
  output logic amb_done,
  output logic proximity_sensing_done,
  output logic [13:0] adc_clear,
  output logic [13:0] adc_red,
  output logic [13:0] adc_green,
  output logic [13:0] adc_blue,
  output logic [13:0] adc_ir,
  output logic [13:0] adc_temp,
  output logic [9:0] adc_proximity_sensing
);
  logic [8:0] ca;
  logic [8:0] cp;
  // Countdowns; zero means idle, one done pulse at the end
  always_ff @(posedge clk_sys) begin
    amb_done <= (ca == 9'h1);
    proximity_sensing_done <= (cp == 9'h1);
    if (reset) begin
      ca <= 9'h0;
      cp <= 9'h0;
    end else begin
      ca <= amb_start ? {1'b0, dly} + 9'h1 : (ca != 9'h0 ? ca - 9'h1 : ca);
      cp <= proximity_sensing_start ? {1'b0, dly} + 9'h1 : (cp != 9'h0 ? cp - 9'h1 : cp);
    end
  end
  // Lines invert outside the done cycle, so stale data never looks valid
  assign adc_clear = amb_val ^ {14{~amb_done}};
  assign adc_red = (amb_val + 14'h1) ^ {14{~amb_done}};
  assign adc_green = (amb_val + 14'h2) ^ {14{~amb_done}};
  assign adc_blue = (amb_val + 14'h3) ^ {14{~amb_done}};
  assign adc_ir = (amb_val + 14'h4) ^ {14{~amb_done}};
  assign adc_temp = (amb_val + 14'h5) ^ {14{~amb_done}};
  assign adc_proximity_sensing = proximity_sensing_val ^ {10{~proximity_sensing_done}};
endmodule

// ---- color_proximity_sensing_sensor_control_tb.sv ----
// Self-checking bench for the sensor control block
`timescale 1ns/1ps
module color_proximity_sensing_sensor_control_tb;
  import color_proximity_sensing_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf, led_current_drive;
  logic pready, pslverr, er, amb_start, amb_done, ir_path_ac, rej_sample;
  logic proximity_sensing_start, proximity_sensing_done, led_pulse, irq, int_pin_oe;
  logic [4:0] amb_ch_en;
  logic [13:0] adc_clear, adc_red, adc_green, adc_blue, adc_ir, adc_temp;
  logic [9:0] adc_proximity_sensing, proximity_sensing_val = 10'h2a5;
  logic [13:0] amb_val = 14'h0123;
  logic [7:0] dly = 8'h1;
  int err_count = 0, checks = 0, cyc = 0, n;
  color_proximity_sensing_sensor_control #(.REPEAT_CYCLES(20)) i_dut (.*);
  color_proximity_sensing_conv_model i_conv (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  task wrap_up;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Look mid-cycle so the answer is read as it stands at the access edge
    @(negedge clk_sys);
    while (pready !== 1'b1) @(negedge clk_sys);
    rd = prdata;
    er = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wait_start;
    @(negedge clk_sys);
    while (amb_start !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask
  // Reset values, unmapped and blank places
  task t_reset;
    apb(0, 8'h00, 8'h0);
    chk("status", rd, 32'h04);
    apb(0, 8'h04, 8'h0);
    chk("main_cfg", rd, 32'h00);
    apb(0, 8'h08, 8'h0);
    chk("amb_cfg", rd, 32'h20);
    apb(0, 8'h0c, 8'h0);
    chk("proximity_sensing_cfg", rd, 32'h02);
    apb(0, 8'h80, 8'h0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(0, 8'h38, 8'h0);
    chk("ircomp", rd, 32'h0);
    chk("ircomp err", er, 1'b0);
  endtask
  // Channel sets per mode with a slow converter, then results
  task t_modes;
    dly = 8'd30;
    for (int m = 0; m < 3; m++) begin
      apb(1, 8'h04, 8'(m << 2));
      wait_start();
      wait_start();
      chk("ch_en", amb_ch_en, m == 0 ? 5'h01 : (m == 1 ? 5'h11 : 5'h1f));
    end
    wait_start();
    apb(0, 8'h10, 8'h0);
    chk("clear hi", rd, 32'h01);
    for (int k = 0; k < 5; k++) begin
      apb(0, 8'(8'h14 + 8 * k), 8'h0);
      chk("result lo", rd, 32'h23 + k);
    end
    apb(0, 8'h4c, 8'h0);
    chk("temp lo", rd, 32'h28);
  endtask
  // Pulse width, drive code and clamp, single pulse per measurement
  task t_led;
    dly = 8'd1;
    apb(1, 8'h04, 8'h0c);
    for (int c = 0; c < 2; c++) begin
      apb(1, 8'h0c, c == 0 ? 8'h30 : 8'hf0);
      while (led_pulse !== 1'b1) @(posedge clk_sys);
      while (led_pulse !== 1'b0) @(posedge clk_sys);
      while (led_pulse !== 1'b1) @(posedge clk_sys);
      n = 0;
      while (led_pulse === 1'b1) begin
        chk("drive", led_current_drive, c == 0 ? 4'h3 : 4'hb);
        n++;
        @(posedge clk_sys);
      end
      chk("width", n, 200);
      repeat (20) begin
        chk("one pulse", led_pulse, 1'b0);
        @(posedge clk_sys);
      end
      chk("ir dc", ir_path_ac, 1'b0);
    end
  endtask
  // Masking, latching and both ways of clearing
  task t_irq;
    apb(1, 8'h54, 8'h10);
    apb(1, 8'h60, 8'h00);
    apb(1, 8'h04, 8'h00);
    wait_start();
    wait_start();
    chk("masked", irq, 1'b0);
    apb(1, 8'h64, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk("irq on", irq, 1'b1);
    apb(1, 8'h04, 8'h18);
    repeat (300) @(posedge clk_sys);
    chk("latched", irq, 1'b1);
    apb(1, 8'h00, 8'h02);
    apb(0, 8'h00, 8'h0);
    chk("status", rd, 32'h01);
    repeat (2) @(posedge clk_sys);
    chk("irq off", irq, 1'b0);
    apb(0, 8'h00, 8'h0);
    chk("cleared", rd, 32'h00);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_modes();
    t_led();
    t_irq();
    wrap_up();
  end
endmodule
